/* File: logic/pwc_hv_pin.sv */
// One high-voltage pin: mode decode and wake static filter.
// Assumes wake_sync is already synchronised to ref_clk.
`default_nettype none
module pwc_hv_pin #(
    parameter int FILT_CYC = pwc_pkg::WAKE_FILTER_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [2:0] mode,
    input  wire logic       fail_wave,
    input  wire logic       wake_sync,
    output pwc_pkg::pwc_pin_t pin,
    output logic            wake_level,
    output logic            wake_event
);
    if (FILT_CYC < 1 || FILT_CYC > 1023) begin : g_bad
        $error("pwc_hv_pin: bad filter count");
    end
    logic [9:0] cnt_reg;
    logic       filt_reg;
    logic       evt_reg;
    wire is_fail = ~mode[2];
    wire is_wake = (mode == pwc_pkg::PWC_MODE_WAKE);
    wire differ  = (wake_sync != filt_reg);
    wire settled = differ && (cnt_reg == 10'(FILT_CYC - 1));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= 10'h000;
            filt_reg <= 1'b0;
            evt_reg  <= 1'b0;
        end else begin
            // Static filter: input must hold for the full time
            cnt_reg  <= (!is_wake || !differ || settled) ? 10'h000
                        : cnt_reg + 10'h001;
            filt_reg <= is_wake ? (settled ? wake_sync : filt_reg)
                        : 1'b0;
            evt_reg  <= is_wake && settled && wake_sync;
        end
    end
    assign pin.fail_out = is_fail & fail_wave;
    assign pin.wake_in  = is_wake;
    assign pin.low_on   = (mode == pwc_pkg::PWC_MODE_LOW);
    assign pin.high_on  = (mode == pwc_pkg::PWC_MODE_HIGH);
    assign wake_level   = filt_reg;
    assign wake_event   = evt_reg;
endmodule : pwc_hv_pin
`default_nettype wire

/* File: logic/pwc_pkg.sv */
// Package: register map, field layout, reset values, timing counts.
// Assumes a 20 MHz ref_clk and byte-wide register access.
`default_nettype none
package pwc_pkg;
    // ****************************************************
    // Register offsets
    // ****************************************************
    localparam logic [6:0] PIN_FUNCTION_CONFIG_OFS = 7'h17;
    localparam logic [6:0] CHANNEL1_DUTY_OFS       = 7'h18;
    localparam logic [6:0] CHANNEL2_DUTY_OFS       = 7'h19;
    localparam logic [6:0] CHANNEL_RATE_SELECT_OFS = 7'h1C;
    localparam logic [7:0] REG_RESET_VAL           = 8'h00;
    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int FAIL_DUTY_LSB = 6;
    localparam int PIN2_MODE_LSB = 3;
    localparam int PIN1_MODE_LSB = 0;
    localparam int CH1_RATE_BIT  = 0;
    localparam int CH2_RATE_BIT  = 2;
    localparam logic [7:0] RATE_WRITE_MASK = 8'h05;
    // ****************************************************
    // Pin modes
    // ****************************************************
    typedef enum logic [2:0] {
        PWC_MODE_OFF  = 3'h4,
        PWC_MODE_WAKE = 3'h5,
        PWC_MODE_LOW  = 3'h6,
        PWC_MODE_HIGH = 3'h7
    } pwc_mode_t;
    typedef struct packed {
        logic       wr_en;
        logic [6:0] addr;
        logic [7:0] wdata;
    } pwc_wr_t;
    typedef struct packed {
        logic fail_out;
        logic wake_in;
        logic low_on;
        logic high_on;
    } pwc_pin_t;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_HZ         = 20_000_000;
    localparam int WAKE_FILTER_NS = 16_000;
    localparam int WAKE_FILTER_CYC =
        (WAKE_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RATE_LOW_HZ  = 200;
    localparam int RATE_HIGH_HZ = 400;
    localparam int STEPS        = 255;
    localparam int TICK_LOW_CYC  = CLK_HZ / (RATE_LOW_HZ * STEPS);
    localparam int TICK_HIGH_CYC = CLK_HZ / (RATE_HIGH_HZ * STEPS);
    // Fail output: 1000 ticks per period, on counts for 20/10/5/2.5 %
    localparam int FAIL_TICK_CYC   = 20_000;
    localparam int FAIL_PERIOD_TK  = 1000;
    localparam int FAIL_ON_20_TK   = 200;
    localparam int FAIL_ON_10_TK   = 100;
    localparam int FAIL_ON_5_TK    = 50;
    localparam int FAIL_ON_2P5_TK  = 25;
endpackage : pwc_pkg
`default_nettype wire

/* File: logic/pwc_pwm_chan.sv */
// One 8-bit duty PWM channel with period-aligned updates.
// Assumes duty and rate come from same-clock registers.
`default_nettype none
module pwc_pwm_chan #(
    parameter int LOW_CYC  = pwc_pkg::TICK_LOW_CYC,
    parameter int HIGH_CYC = pwc_pkg::TICK_HIGH_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [7:0] duty,
    input  wire logic       rate_fast,
    output logic            pwm_out
);
    if (HIGH_CYC < 1 || LOW_CYC < HIGH_CYC || LOW_CYC > 65535) begin : g_bad
        $error("pwc_pwm_chan: bad tick counts");
    end
    logic [15:0] pre_reg;
    logic [7:0]  step_reg;
    logic [7:0]  duty_reg;
    logic        fast_reg;
    logic        out_reg;
    wire  [15:0] pre_max   = fast_reg ? 16'(HIGH_CYC - 1) : 16'(LOW_CYC - 1);
    wire         tick      = (pre_reg >= pre_max);
    wire         period_end = tick && (step_reg == 8'hFE);
    wire  [7:0]  step_next = period_end ? 8'h00 : step_reg + 8'h01;
    // Latch new settings only at period boundary
    wire  [7:0]  duty_next = period_end ? duty : duty_reg;
    wire         fast_next = period_end ? rate_fast : fast_reg;
    // On while step below duty; 255 covers all steps
    wire         on_next   = (step_next < duty_next);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_reg  <= 16'h0000;
            step_reg <= 8'h00;
            duty_reg <= 8'h00;
            fast_reg <= 1'b0;
            out_reg  <= 1'b0;
        end else begin
            pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
            if (tick) begin
                step_reg <= step_next;
                duty_reg <= duty_next;
                fast_reg <= fast_next;
                out_reg  <= on_next;
            end
        end
    end
    assign pwm_out = out_reg;
endmodule : pwc_pwm_chan
`default_nettype wire

/* File: logic/pwc_top.sv */
// Top: configuration registers, two PWM channels, two HV pins.
// Assumes a serial front end delivers decoded byte writes on ref_clk.
// Behaviour
// - Bits 7:6 pick fail output 3 duty 20, 10, 5 or 2.5 percent.
// - Pin mode codes: 0-3 fail, 4 off, 5 wake, 6 low, 7 high.
// - Wake input passes a 16 us static filter before an event.
// - Channel 1 duty: 0 off, 255 on, else value/255 on.
// - Channel 2 duty decodes exactly like channel 1.
// - Rate bit 0 picks channel 1 200 Hz or 400 Hz.
// - Rate bit 2 picks channel 2 200 Hz or 400 Hz.
// - Reserved rate bits read zero and ignore writes.
// - Minimum on-time set by switch timing; one step invisible.
// - PWM period comes from the internal system clock.
// - All four registers clear on power-on and soft reset.
`default_nettype none
module pwc_top #(
    parameter int PWM_LOW_CYC  = pwc_pkg::TICK_LOW_CYC,
    parameter int PWM_HIGH_CYC = pwc_pkg::TICK_HIGH_CYC,
    parameter int FAIL_TICK    = pwc_pkg::FAIL_TICK_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             soft_rst,
    input  wire pwc_pkg::pwc_wr_t wr,
    input  wire logic [6:0]       rd_addr,
    output logic [7:0]            rd_data,
    input  wire logic             pin1_wake_raw,
    input  wire logic             pin2_wake_raw,
    output pwc_pkg::pwc_pin_t     pin1,
    output pwc_pkg::pwc_pin_t     pin2,
    output logic                  fail_output_2,
    output logic                  fail_output_3,
    output logic                  pin1_wake_event,
    output logic                  pin2_wake_event,
    output logic                  pin1_wake_level,
    output logic                  pin2_wake_level,
    output logic                  channel1_pwm,
    output logic                  channel2_pwm
);
    // Fail prescaler is 15 bits wide
    if (FAIL_TICK < 1 || FAIL_TICK > 32768) begin : g_bad_fail
        $error("pwc_top: bad fail tick count");
    end
    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0] pin_function_config_reg;
    logic [7:0] channel1_duty_reg;
    logic [7:0] channel2_duty_reg;
    logic [7:0] channel_rate_select_reg;
    logic [7:0] rd_data_reg;

    wire we_cfg  = wr.wr_en && (wr.addr == pwc_pkg::PIN_FUNCTION_CONFIG_OFS);
    wire we_d1   = wr.wr_en && (wr.addr == pwc_pkg::CHANNEL1_DUTY_OFS);
    wire we_d2   = wr.wr_en && (wr.addr == pwc_pkg::CHANNEL2_DUTY_OFS);
    wire we_rate = wr.wr_en && (wr.addr == pwc_pkg::CHANNEL_RATE_SELECT_OFS);
    wire [7:0] rate_wdata = wr.wdata & pwc_pkg::RATE_WRITE_MASK;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_function_config_reg <= pwc_pkg::REG_RESET_VAL;
            channel1_duty_reg       <= pwc_pkg::REG_RESET_VAL;
            channel2_duty_reg       <= pwc_pkg::REG_RESET_VAL;
            channel_rate_select_reg <= pwc_pkg::REG_RESET_VAL;
        end else if (soft_rst) begin
            pin_function_config_reg <= pwc_pkg::REG_RESET_VAL;
            channel1_duty_reg       <= pwc_pkg::REG_RESET_VAL;
            channel2_duty_reg       <= pwc_pkg::REG_RESET_VAL;
            channel_rate_select_reg <= pwc_pkg::REG_RESET_VAL;
        end else begin
            if (we_cfg)  pin_function_config_reg <= wr.wdata;
            if (we_d1)   channel1_duty_reg       <= wr.wdata;
            if (we_d2)   channel2_duty_reg       <= wr.wdata;
            if (we_rate) channel_rate_select_reg <= rate_wdata;
        end
    end

    // ****************************************************
    // Read back
    // ****************************************************
    logic [7:0] rd_mux;
    always_comb begin
        unique case (rd_addr)
            pwc_pkg::PIN_FUNCTION_CONFIG_OFS: rd_mux = pin_function_config_reg;
            pwc_pkg::CHANNEL1_DUTY_OFS:       rd_mux = channel1_duty_reg;
            pwc_pkg::CHANNEL2_DUTY_OFS:       rd_mux = channel2_duty_reg;
            pwc_pkg::CHANNEL_RATE_SELECT_OFS: rd_mux = channel_rate_select_reg;
            default:                          rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) rd_data_reg <= 8'h00;
        else     rd_data_reg <= rd_mux;
    end
    assign rd_data = rd_data_reg;

    // ****************************************************
    // Field decode
    // ****************************************************
    wire [1:0] fail_out_duty_sel =
        pin_function_config_reg[pwc_pkg::FAIL_DUTY_LSB +: 2];
    wire [2:0] hv_pin1_mode =
        pin_function_config_reg[pwc_pkg::PIN1_MODE_LSB +: 3];
    wire [2:0] hv_pin2_mode =
        pin_function_config_reg[pwc_pkg::PIN2_MODE_LSB +: 3];
    wire       channel1_rate_sel =
        channel_rate_select_reg[pwc_pkg::CH1_RATE_BIT];
    wire       channel2_rate_sel =
        channel_rate_select_reg[pwc_pkg::CH2_RATE_BIT];

    // ****************************************************
    // Fail output waveforms
    // ****************************************************
    function automatic logic [9:0] fail_on_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h0: fail_on_ticks = 10'(pwc_pkg::FAIL_ON_20_TK);
            2'h1: fail_on_ticks = 10'(pwc_pkg::FAIL_ON_10_TK);
            2'h2: fail_on_ticks = 10'(pwc_pkg::FAIL_ON_5_TK);
            2'h3: fail_on_ticks = 10'(pwc_pkg::FAIL_ON_2P5_TK);
        endcase
    endfunction : fail_on_ticks

    logic [14:0] fpre_reg;
    logic [9:0]  fstep_reg;
    logic        f3_reg;
    logic        f2_reg;
    wire ftick   = (fpre_reg == 15'(FAIL_TICK - 1));
    wire fwrap   = ftick && (fstep_reg == 10'(pwc_pkg::FAIL_PERIOD_TK - 1));
    wire [9:0] fstep_next = fwrap ? 10'h000 : fstep_reg + 10'h001;
    wire [9:0] f3_on = fail_on_ticks(fail_out_duty_sel);
    // Fail output 2 runs at a fixed half duty
    wire [9:0] f2_on = 10'(pwc_pkg::FAIL_PERIOD_TK / 2);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fpre_reg  <= 15'h0000;
            fstep_reg <= 10'h000;
            f3_reg    <= 1'b0;
            f2_reg    <= 1'b0;
        end else begin
            fpre_reg <= ftick ? 15'h0000 : fpre_reg + 15'h0001;
            if (ftick) begin
                fstep_reg <= fstep_next;
                f3_reg    <= (fstep_next < f3_on);
                f2_reg    <= (fstep_next < f2_on);
            end
        end
    end
    assign fail_output_2 = f2_reg;
    assign fail_output_3 = f3_reg;

    // ****************************************************
    // Wake input synchronisers
    // ****************************************************
    logic [1:0] w1_sync_reg;
    logic [1:0] w2_sync_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w1_sync_reg <= 2'h0;
            w2_sync_reg <= 2'h0;
        end else begin
            w1_sync_reg <= {w1_sync_reg[0], pin1_wake_raw};
            w2_sync_reg <= {w2_sync_reg[0], pin2_wake_raw};
        end
    end

    // ****************************************************
    // Sub-blocks
    // ****************************************************
    // Pin 1 hosts fail output 2, pin 2 fail output 3
    pwc_hv_pin u_pin1 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .mode       (hv_pin1_mode),
        .fail_wave  (f2_reg),
        .wake_sync  (w1_sync_reg[1]),
        .pin        (pin1),
        .wake_level (pin1_wake_level),
        .wake_event (pin1_wake_event)
    );
    pwc_hv_pin u_pin2 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .mode       (hv_pin2_mode),
        .fail_wave  (f3_reg),
        .wake_sync  (w2_sync_reg[1]),
        .pin        (pin2),
        .wake_level (pin2_wake_level),
        .wake_event (pin2_wake_event)
    );
    // One-step pulses are produced; the switch swallows them
    pwc_pwm_chan #(
        .LOW_CYC  (PWM_LOW_CYC),
        .HIGH_CYC (PWM_HIGH_CYC)
    ) u_ch1 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .duty      (channel1_duty_reg),
        .rate_fast (channel1_rate_sel),
        .pwm_out   (channel1_pwm)
    );
    pwc_pwm_chan #(
        .LOW_CYC  (PWM_LOW_CYC),
        .HIGH_CYC (PWM_HIGH_CYC)
    ) u_ch2 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .duty      (channel2_duty_reg),
        .rate_fast (channel2_rate_sel),
        .pwm_out   (channel2_pwm)
    );
endmodule : pwc_top
`default_nettype wire

/* File: verif/pwc_pin_model.sv */
// Partner: outside drivers facing the two high-voltage wake inputs.
// Assumes a pull-down holds each pin low whenever it is released.
`default_nettype none
module pwc_pin_model (
    input  wire logic [1:0] drv_en,
    input  wire logic [1:0] drv_lvl,
    output logic            pin1_wake_raw,
    output logic            pin2_wake_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pin falls to the pull-down level
    assign pin1_wake_raw = drv_en[0] & drv_lvl[0];
    assign pin2_wake_raw = drv_en[1] & drv_lvl[1];
endmodule : pwc_pin_model
`default_nettype wire

/* File: verif/pwc_top_monitor.sv */
// Checker: port-level assertions for the configuration and PWM top.
// Assumes it is bound to pwc_top and sees only that module's ports.
`default_nettype none
module pwc_top_monitor (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              soft_rst,
    input wire pwc_pkg::pwc_wr_t  wr,
    input wire logic [6:0]        rd_addr,
    input wire logic [7:0]        rd_data,
    input wire pwc_pkg::pwc_pin_t pin1,
    input wire logic              pin1_wake_raw,
    input wire logic              pin1_wake_level,
    input wire logic              pin1_wake_event,
    input wire logic              channel1_pwm,
    input wire logic              channel2_pwm
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************
    // Helper counters
    // ****************************************************
    logic [9:0] run_cyc_reg;
    logic [9:0] raw_cyc_reg;
    logic       raw_last_reg;
    wire        mapped = rd_addr inside {pwc_pkg::PIN_FUNCTION_CONFIG_OFS,
        pwc_pkg::CHANNEL1_DUTY_OFS, pwc_pkg::CHANNEL2_DUTY_OFS,
        pwc_pkg::CHANNEL_RATE_SELECT_OFS};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_cyc_reg  <= 10'h000;
            raw_cyc_reg  <= 10'h000;
            raw_last_reg <= 1'b0;
        end else begin
            if (run_cyc_reg != 10'h3FF) run_cyc_reg <= run_cyc_reg + 10'h001;
            raw_last_reg <= pin1_wake_raw;
            if (pin1_wake_raw != raw_last_reg) raw_cyc_reg <= 10'h000;
            else if (raw_cyc_reg != 10'h3FF) raw_cyc_reg <= raw_cyc_reg + 10'h001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ****************************************************
    // Assertions
    // ****************************************************
    chk_unmapped_read: assert property (!mapped |=> rd_data == 8'h00)
        else $error("unmapped address read back nonzero");
    chk_rate_reserved: assert property (rd_addr ==
        pwc_pkg::CHANNEL_RATE_SELECT_OFS |=> (rd_data & 8'hFA) == 8'h00)
        else $error("reserved rate bits read nonzero");
    chk_write_read_back: assert property ((wr.wr_en && wr.addr == rd_addr
        && mapped && rd_addr != pwc_pkg::CHANNEL_RATE_SELECT_OFS && !soft_rst)
        ##1 ($stable(rd_addr) && !wr.wr_en && !soft_rst)
        |=> rd_data == $past(wr.wdata, 2))
        else $error("written byte not read back");
    chk_soft_clear: assert property (soft_rst && !wr.wr_en |=> ##1
        rd_data == 8'h00) else $error("register kept value over soft reset");
    chk_first_period_off: assert property (run_cyc_reg < 10'h3E8 |->
        !channel1_pwm && !channel2_pwm) else $error("pwm high after reset");
    chk_pin_one_mode: assert property ($onehot0(pin1))
        else $error("pin shows two functions at once");
    chk_wake_filter_len: assert property ($rose(pin1_wake_level) |->
        raw_cyc_reg >= 10'h140) else $error("wake level passed short input");
    chk_wake_event_edge: assert property (pin1_wake_event |->
        pin1_wake_level && !$past(pin1_wake_level))
        else $error("wake event without rising level");
    chk_wake_event_single: assert property (pin1_wake_event |=>
        !pin1_wake_event) else $error("wake event longer than one cycle");
    cov_wake_rise: cover property ($rose(pin1_wake_level));
    cov_soft_reset: cover property (soft_rst);
    cov_rate_write: cover property (wr.wr_en &&
        wr.addr == pwc_pkg::CHANNEL_RATE_SELECT_OFS);
endmodule : pwc_top_monitor
bind pwc_top pwc_top_monitor i_mon (.ref_clk(ref_clk), .rst(rst),
    .soft_rst(soft_rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .pin1(pin1), .pin1_wake_raw(pin1_wake_raw),
    .pin1_wake_level(pin1_wake_level), .pin1_wake_event(pin1_wake_event),
    .channel1_pwm(channel1_pwm), .channel2_pwm(channel2_pwm));
`default_nettype wire

/* File: verif/test_pwc_top.sv */
// Testbench: register access, pin modes, wake filter and PWM duty.
// Assumes the partner model and checker are compiled alongside.
`default_nettype none
module test_pwc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic              ref_clk, rst, soft_rst, lv1, lv2, ev1, ev2;
    pwc_pkg::pwc_wr_t  wr;
    logic [6:0]        rd_addr;
    logic [7:0]        rd_data;
    logic [1:0]        drv_en, drv_lvl;
    logic              p1_raw, p2_raw, fo2, fo3, pwm1, pwm2;
    // Short tick counts keep a slow PWM period at 1530 cycles
    localparam int     LOW_T  = 6;
    localparam int     HIGH_T = 3;
    localparam int     FAIL_T = 2;
    pwc_pkg::pwc_pin_t pin1, pin2;
    int                err_total, n_compared, ev_cnt;
    logic [6:0] ofs [4] = '{pwc_pkg::PIN_FUNCTION_CONFIG_OFS,
        pwc_pkg::CHANNEL1_DUTY_OFS, pwc_pkg::CHANNEL2_DUTY_OFS,
        pwc_pkg::CHANNEL_RATE_SELECT_OFS};
    logic [7:0] duties [5] = '{8'h00, 8'h01, 8'h80, 8'hFE, 8'hFF};
    // Fail output 3 on-cycles per 2000-cycle period: 20, 10, 5, 2.5 %
    int         fo_on [4] = '{400, 200, 100, 50};
    pwc_top #(.PWM_LOW_CYC(LOW_T), .PWM_HIGH_CYC(HIGH_T),
        .FAIL_TICK(FAIL_T)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .soft_rst(soft_rst),
        .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data), .pin1_wake_raw(p1_raw),
        .pin2_wake_raw(p2_raw), .pin1(pin1), .pin2(pin2), .fail_output_2(fo2),
        .fail_output_3(fo3), .pin1_wake_event(ev1), .pin2_wake_event(ev2),
        .pin1_wake_level(lv1), .pin2_wake_level(lv2), .channel1_pwm(pwm1),
        .channel2_pwm(pwm2));
    pwc_pin_model i_pins (.drv_en(drv_en), .drv_lvl(drv_lvl),
        .pin1_wake_raw(p1_raw), .pin2_wake_raw(p2_raw));
    // ****************************************************
    // Clock, tasks, watchdog
    // ****************************************************
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
        ev_cnt += int'(ev1 === 1'b1) + int'(ev2 === 1'b1);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        wr = '{1'b1, a, d};
        rd_addr = a;
        @(negedge ref_clk);
        wr.wr_en = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        rd_addr = a;
        @(negedge ref_clk);
        check({8'h00, rd_data}, {8'h00, exp});
    endtask : rd_chk
    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (70000) @(posedge ref_clk);
        err_total++;
        $display("unexpected at %0t: run timed out", $time);
        print_verdict();
    end
    // ****************************************************
    // Test sequence
    // ****************************************************
    initial begin
        logic [3:0] e, mk;
        int hi, hi2, per, mm;
        rst = 1'b1;
        soft_rst = 1'b0;
        wr = '0;
        rd_addr = 7'h00;
        drv_en = 2'b00;
        drv_lvl = 2'b00;
        err_total = 0;
        n_compared = 0;
        ev_cnt = 0;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
        rd_chk(7'h1A, 8'h00);
        wr_reg(ofs[3], 8'hFF);
        rd_chk(ofs[3], 8'h05);
        wr_reg(ofs[3], 8'hFA);
        rd_chk(ofs[3], 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr_reg(ofs[0], {m[1:0], m[2:0], m[2:0]});
            rd_chk(ofs[0], {m[1:0], m[2:0], m[2:0]});
            e = {1'b0, m == 5, m == 6, m == 7};
            mk = (m < 4) ? 4'h7 : 4'hF;
            check({12'h000, 4'(pin1) & mk}, {12'h000, e});
            check({12'h000, 4'(pin2) & mk}, {12'h000, e});
        end
        foreach (ofs[i]) wr_reg(ofs[i], 8'h5A);
        @(negedge ref_clk);
        soft_rst = 1'b1;
        @(negedge ref_clk);
        soft_rst = 1'b0;
        foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
        wr_reg(ofs[0], 8'h2D);
        drv_en = 2'b11;
        drv_lvl = 2'b11;
        repeat (200) @(negedge ref_clk);
        drv_lvl = 2'b00;
        repeat (400) @(negedge ref_clk);
        check({14'h0000, lv1, lv2}, 16'h0000);
        drv_lvl = 2'b11;
        repeat (300) @(negedge ref_clk);
        check({14'h0000, lv1, lv2}, 16'h0000);
        repeat (40) @(negedge ref_clk);
        check({14'h0000, lv1, lv2}, 16'h0003);
        check(16'(ev_cnt), 16'h0002);
        drv_en = 2'b00;
        repeat (400) @(negedge ref_clk);
        check({14'h0000, lv1, lv2}, 16'h0000);
        // Both pins on fail outputs, one full fail period per code
        for (int s = 0; s < 4; s++) begin
            wr_reg(ofs[0], {s[1:0], 6'h00});
            repeat (4) @(negedge ref_clk);
            hi = 0;
            hi2 = 0;
            mm = 0;
            repeat (pwc_pkg::FAIL_PERIOD_TK * FAIL_T) begin
                @(negedge ref_clk);
                hi += int'(fo3 === 1'b1);
                hi2 += int'(fo2 === 1'b1);
                mm += int'(pin1.fail_out !== fo2 || pin2.fail_out !== fo3);
            end
            check(16'(hi), 16'(fo_on[s]));
            check(16'(hi2), 16'(pwc_pkg::FAIL_PERIOD_TK / 2 * FAIL_T));
            check(16'(mm), 16'h0000);
        end
        for (int r = 0; r < 2; r++) begin
            foreach (duties[k]) begin
                wr_reg(ofs[1], duties[k]);
                wr_reg(ofs[2], duties[4 - k]);
                wr_reg(ofs[3], r[0] ? 8'h05 : 8'h00);
                per = 255 * (r[0] ? HIGH_T : LOW_T);
                // Old slow period may still run before new values apply
                repeat (2 * 255 * LOW_T + 4) @(negedge ref_clk);
                hi = 0;
                hi2 = 0;
                repeat (per) begin
                    @(negedge ref_clk);
                    hi += int'(pwm1 === 1'b1);
                    hi2 += int'(pwm2 === 1'b1);
                end
                check(16'(hi), 16'(duties[k] * per / 255));
                check(16'(hi2), 16'(duties[4 - k] * per / 255));
            end
        end
        print_verdict();
    end
endmodule : test_pwc_top
`default_nettype wire
